// File: pkg/dslc_defines.svh
// Constants for the serial load control of a 12-bit converter.
// Assumes inclusion by bare name from the package and the design file.
`ifndef DSLC_DEFINES_SVH
`define DSLC_DEFINES_SVH

`define DSLC_FRAME_W      16
`define DSLC_DATA_W       12
`define DSLC_PM_W         2
`define DSLC_CNT_W        5
`define DSLC_FRAME_MSB    15
`define DSLC_FIFO_DEPTH   8
`define DSLC_PM_NORMAL    2'h0
`define DSLC_PM_PD_1K     2'h1
`define DSLC_PM_PD_100K   2'h2
`define DSLC_PM_PD_HIZ    2'h3
`define DSLC_ZERO_CODE    12'h000
`define DSLC_ZERO_FRAME   16'h0000
`define DSLC_ZERO_CNT     5'h00
`define DSLC_ONE_CNT      5'h01
`define DSLC_FULL_CNT     5'h10
`define DSLC_CORE_NS      100
`define DSLC_LINK_NS      800

`endif

// File: pkg/dslc_pkg.sv
// Types for the serial load control core; its FIFO uses none of them.
// Assumes dslc_defines.svh on the include path.
`include "dslc_defines.svh"

package dslc_pkg;

	typedef enum logic [`DSLC_PM_W-1:0] {
		DSLC_PM_NORMAL  = `DSLC_PM_NORMAL,
		DSLC_PM_PD_1K   = `DSLC_PM_PD_1K,
		DSLC_PM_PD_100K = `DSLC_PM_PD_100K,
		DSLC_PM_PD_HIZ  = `DSLC_PM_PD_HIZ
	} dslc_pmode_e;

	typedef struct packed {
		logic [1:0]               ignored;
		dslc_pmode_e              power_mode;
		logic [`DSLC_DATA_W-1:0]  data_field;
	} dslc_frame_s;

	typedef enum logic [1:0] {
		DSLC_LINK_IDLE  = 2'h1,
		DSLC_LINK_FRAME = 2'h2
	} dslc_link_e;

endpackage : dslc_pkg

// File: logic/dslc_core.sv
// Serial load control of a single 12-bit converter, plus its frame FIFO.
// Assumes one 10 MHz core clock; every link pin is asynchronous to it and
// the link clock runs well below half the core rate.
//
// Behaviour
// RL1: A 16-bit shift register loads each frame under the serial clock.
// RL2: Frame is four control bits then a 12-bit data field in low bits.
// RL3: Bits arrive most significant first, bit 15 down to bit 0.
// RL4: Frame bits 15 and 14 are ignored whatever their value.
// RL5: Data field is unsigned straight binary, zero to full scale minus one.
// RL6: Bits 13:12 choose normal or one of three power-down terminations.
// RL7: Bits are accepted only while the active-low frame select is low.
// RL8: One bit is captured per falling serial clock edge after select falls.
// RL9: Shifting continues past sixteen edges, older bits leaving the register.
// RL10: Rising frame select copies the latest 16 bits to the converter register.
// RL11: At power-up all registers clear and the output sits at zero scale.
// RL12: Low clear input resets all registers and forces zero scale; the code leaves link_reg and serial_out_oe_reg running through clear.
// RL13: After clear releases, the next update is the first select rising edge.
// RL14: Serial output is high impedance while frame select is high.
// RL15: With select low, serial output is the register end, input delayed 16.
// RL16: Host gives 16 times n falling edges for n chained parts, then raises select.
// RL17: Host keeps the serial clock at most 50 MHz alone, 10 MHz chained.
// RL18: While clear is low the converter register holds the all-zero code.
// RL19: Host starts every frame with a falling edge of frame select.
// RL20: A power-down mode persists until a later frame selects normal mode.
`timescale 1ns/1ns
`include "dslc_defines.svh"

module dslc_fifo #(
	parameter int WIDTH = `DSLC_FRAME_W,
	parameter int DEPTH = `DSLC_FIFO_DEPTH
) (
	input  wire logic             core_clk_i,
	input  wire logic             rst_i,
	input  wire logic             flush_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic [AW:0]      count_next;
	wire              push;
	wire              pop;

	assign in_ready_o  = (count_reg != DEPTH_C);
	assign out_valid_o = (count_reg != '0);
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;
	assign out_data_o  = mem[rd_ptr_reg];
	assign count_next  = count_reg + (AW+1)'(push) - (AW+1)'(pop);

	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
	endfunction : ptr_inc

	always_ff @(posedge core_clk_i) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data_i;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i || flush_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= ptr_inc(wr_ptr_reg);
			end
			if (pop) begin
				rd_ptr_reg <= ptr_inc(rd_ptr_reg);
			end
			count_reg <= count_next;
		end
	end

	fifo_bound_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		count_reg <= DEPTH_C)
		else $error("fifo count beyond depth");

endmodule : dslc_fifo

module dslc_core (
	input  wire logic                    core_clk_i,
	input  wire logic                    rst_i,
	input  wire logic                    serial_clk_i,
	input  wire logic                    frame_sel_n_i,
	input  wire logic                    serial_in_i,
	input  wire logic                    async_clear_n_i,
	input  wire logic                    conv_ready_i,
	output logic                         serial_out_o,
	output logic                         serial_out_oe_o,
	output logic                         frame_ready_o,
	output logic [`DSLC_DATA_W-1:0]      dac_code_o,
	output dslc_pkg::dslc_pmode_e        power_mode_o,
	output logic                         update_o
);
	// Link clock period in the bench, against the core period
	localparam int LINK_OVERSAMPLE = `DSLC_LINK_NS / `DSLC_CORE_NS;

	// Two-flop synchronisers, plus a third stage only for edge finding
	logic [2:0] sclk_sync_reg;
	logic [1:0] sel_sync_reg;
	logic [1:0] sin_sync_reg;
	logic [1:0] clear_sync_reg;

	logic [`DSLC_FRAME_W-1:0] shift_reg;
	logic [`DSLC_FRAME_W-1:0] shift_next;
	logic [`DSLC_CNT_W-1:0]   bit_cnt_reg;
	logic [`DSLC_CNT_W-1:0]   bit_cnt_next;
	logic                     serial_out_oe_reg;
	logic [`DSLC_DATA_W-1:0]  code_reg;
	dslc_pkg::dslc_pmode_e    pmode_reg;
	logic                     update_reg;
	dslc_pkg::dslc_link_e     link_reg;
	dslc_pkg::dslc_link_e     link_next;

	wire                      sclk_fall;
	wire                      sel_low;
	wire                      clear_active;
	wire                      sin_s;
	wire                      shift_en;
	wire                      sel_rise;
	wire                      push_valid;
	wire                      push_ready;
	wire                      pop_valid;
	wire                      pop;
	wire                      pop_normal;
	wire [`DSLC_FRAME_W-1:0]  pop_raw;
	dslc_pkg::dslc_frame_s    pop_frame;

	function automatic logic mode_is_normal(input dslc_pkg::dslc_pmode_e m);
		mode_is_normal = (m == dslc_pkg::DSLC_PM_NORMAL);
	endfunction : mode_is_normal

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			sclk_sync_reg  <= 3'h7;
			sel_sync_reg   <= 2'h3;
			sin_sync_reg   <= 2'h0;
			clear_sync_reg <= 2'h3;
		end else begin
			sclk_sync_reg  <= {sclk_sync_reg[1:0], serial_clk_i};
			sel_sync_reg   <= {sel_sync_reg[0], frame_sel_n_i};
			sin_sync_reg   <= {sin_sync_reg[0], serial_in_i};
			clear_sync_reg <= {clear_sync_reg[0], async_clear_n_i};
		end
	end

	assign sclk_fall    = sclk_sync_reg[2] && !sclk_sync_reg[1];
	assign sel_low      = !sel_sync_reg[1];
	assign clear_active = !clear_sync_reg[1];
	assign sin_s        = sin_sync_reg[1];

	// Frame tracking follows the select even during clear, so a frame
	// that spans the clear release still latches at its rising edge
	always_comb begin
		link_next = link_reg;
		unique case (link_reg)
			dslc_pkg::DSLC_LINK_IDLE: begin
				if (sel_low) begin
					link_next = dslc_pkg::DSLC_LINK_FRAME; // see RL19
				end
			end
			dslc_pkg::DSLC_LINK_FRAME: begin
				if (!sel_low) begin
					link_next = dslc_pkg::DSLC_LINK_IDLE;
				end
			end
			default: begin
				link_next = dslc_pkg::DSLC_LINK_IDLE;
			end
		endcase
	end

	assign shift_en = (link_reg == dslc_pkg::DSLC_LINK_FRAME) && sel_low
		&& sclk_fall; // see RL7
	assign sel_rise = (link_reg == dslc_pkg::DSLC_LINK_FRAME) && !sel_low;

	// Msb first: each new bit enters at bit 0, oldest falls out of bit 15
	assign shift_next = shift_en ? {shift_reg[`DSLC_FRAME_MSB-1:0], sin_s}
		: shift_reg; // see RL1 see RL3 see RL8 see RL9
	assign bit_cnt_next = sel_rise ? `DSLC_ZERO_CNT
		: (shift_en && bit_cnt_reg != `DSLC_FULL_CNT) ? bit_cnt_reg + `DSLC_ONE_CNT
		: bit_cnt_reg;

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			link_reg <= dslc_pkg::DSLC_LINK_IDLE;
		end else begin
			link_reg <= link_next;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i || clear_active) begin
			shift_reg   <= `DSLC_ZERO_FRAME; // see RL11 see RL12
			bit_cnt_reg <= `DSLC_ZERO_CNT;
		end else begin
			shift_reg   <= shift_next;
			bit_cnt_reg <= bit_cnt_next;
		end
	end

	// Output enable is a flop so the pin never glitches on decode
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			serial_out_oe_reg <= 1'b0;
		end else begin
			serial_out_oe_reg <= sel_low; // see RL14
		end
	end

	assign serial_out_o    = shift_reg[`DSLC_FRAME_MSB]; // see RL15
	assign serial_out_oe_o = serial_out_oe_reg;

	// Latched frames queue here; a full queue drops the frame and shows
	// it on frame_ready_o rather than stalling the pins we cannot stall
	assign push_valid    = sel_rise && !clear_active; // see RL10 see RL13
	assign frame_ready_o = push_ready;

	dslc_fifo #(
		.WIDTH (`DSLC_FRAME_W),
		.DEPTH (`DSLC_FIFO_DEPTH)
	) u_fifo (
		.core_clk_i  (core_clk_i),
		.rst_i       (rst_i),
		.flush_i     (clear_active),
		.in_valid_i  (push_valid),
		.in_ready_o  (push_ready),
		.in_data_i   (shift_reg),
		.out_valid_o (pop_valid),
		.out_ready_i (conv_ready_i),
		.out_data_o  (pop_raw)
	);

	assign pop        = pop_valid && conv_ready_i;
	assign pop_frame  = dslc_pkg::dslc_frame_s'(pop_raw);
	assign pop_normal = mode_is_normal(pop_frame.power_mode);

	// Bits 15:14 never reach any register below
	always_ff @(posedge core_clk_i) begin
		if (rst_i || clear_active) begin
			code_reg   <= `DSLC_ZERO_CODE; // see RL11 see RL12 see RL18
			pmode_reg  <= dslc_pkg::DSLC_PM_NORMAL;
			update_reg <= 1'b0;
		end else begin
			update_reg <= pop;
			if (pop) begin
				pmode_reg <= pop_frame.power_mode; // see RL6 see RL20
				if (pop_normal) begin
					code_reg <= pop_frame.data_field; // see RL2 see RL4 see RL5
				end
			end
		end
	end

	assign dac_code_o   = code_reg;
	assign power_mode_o = pmode_reg;
	assign update_o     = update_reg;

	shift_on_fall_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // see RL8
		shift_en && !clear_active
		|=> shift_reg == {$past(shift_reg[`DSLC_FRAME_MSB-1:0]), $past(sin_s)})
		else $error("bit not shifted in on falling serial clock");

	hold_when_idle_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // see RL7
		!sel_low && !clear_active && !$past(sel_low) |=> $stable(shift_reg))
		else $error("shift register moved while select high");

	count_saturate_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // see RL9
		bit_cnt_reg == `DSLC_FULL_CNT && shift_en && !clear_active
		|=> bit_cnt_reg == `DSLC_FULL_CNT && shift_reg[0] == $past(sin_s))
		else $error("shifting stopped after sixteen edges");

	latch_on_rise_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // see RL10
		$fell(sel_low) && !clear_active && !pop_valid
		|=> pop_valid && pop_raw == $past(shift_reg))
		else $error("rising select did not latch the frame");

	out_hiz_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // see RL14
		!sel_low ##1 !sel_low |-> !serial_out_oe_o)
		else $error("serial output driven while select high");

	out_delay_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // see RL15
		shift_en && !clear_active
		|=> serial_out_o == $past(shift_reg[`DSLC_FRAME_MSB-1]))
		else $error("serial output not the register end");

	clear_zero_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // see RL18
		clear_active |=> dac_code_o == `DSLC_ZERO_CODE
			&& power_mode_o == dslc_pkg::DSLC_PM_NORMAL && !update_o)
		else $error("clear did not force zero scale");

	normal_load_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // see RL5
		pop && pop_normal && !clear_active |=> update_o
			&& dac_code_o == $past(pop_raw[`DSLC_DATA_W-1:0]))
		else $error("normal frame data not loaded");

	pd_keeps_code_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // see RL20
		pop && !pop_normal && !clear_active |=> $stable(dac_code_o)
			&& power_mode_o == $past(pop_frame.power_mode))
		else $error("power-down frame disturbed the code");

	link_onehot_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		$onehot(link_reg) && LINK_OVERSAMPLE > 2)
		else $error("link state not one-hot");

endmodule : dslc_core

// File: test/dslc_host_model.sv
// Host model of the serial link: frame select, link clock and data.
// Assumes the core samples these pins with its own unrelated clock.
`timescale 1ns/1ns

module dslc_host_model (
	output logic        serial_clk_o,
	output logic        frame_sel_n_o,
	output logic        serial_in_o,
	input  wire logic   serial_out_i,
	output logic [31:0] out_cap_o
);
	// Link clock idles high; between frames only idle_clocks moves it
	initial begin
		serial_clk_o  = 1'b1;
		frame_sel_n_o = 1'b1;
		serial_in_o   = 1'b0;
		out_cap_o     = 32'h0000_0000;
	end

	// Sample late in the bit, once the core has had time to shift
	always @(negedge serial_clk_o) begin
		#750 out_cap_o = {out_cap_o[30:0], serial_out_i};
	end

	task automatic open_frame();
		#37 frame_sel_n_o = 1'b0;
		#400;
	endtask : open_frame

	task automatic shift_word(input logic [15:0] w);
		for (int i = 15; i >= 0; i--) begin
			serial_in_o = w[i];
			#400 serial_clk_o = 1'b0;
			#400 serial_clk_o = 1'b1;
		end
	endtask : shift_word

	// Stray edges with select high; the core must not shift on them
	task automatic idle_clocks(input int n);
		for (int i = 0; i < n; i++) begin
			serial_in_o = 1'b1;
			#400 serial_clk_o = 1'b0;
			#400 serial_clk_o = 1'b1;
		end
	endtask : idle_clocks

	task automatic close_frame();
		// Released data is inverted so a stale bit cannot pass as valid
		serial_in_o = ~serial_in_o;
		#400 frame_sel_n_o = 1'b1;
		#400;
	endtask : close_frame
endmodule : dslc_host_model

// File: test/dslc_core_tb.sv
// Self-checking bench for the serial load control core.
// Assumes the host model drives the link pins, the bench the rest.
`timescale 1ns/1ns

module dslc_core_tb;
	typedef struct packed {
		logic [15:0] frame;
		logic [15:0] code;
		logic [15:0] mode;
	} dslc_row_s;

	logic                  core_clk_i, rst_i, async_clear_n_i, conv_ready_i;
	logic                  serial_clk, frame_sel_n, serial_in, serial_out, serial_out_oe;
	logic                  frame_ready, update, serial_out_line;
	logic [11:0]           dac_code;
	dslc_pkg::dslc_pmode_e power_mode;
	logic [31:0]           out_cap;
	int                    mismatches, checks, cyc, upd_cnt;
	dslc_row_s             rows [7] = '{
		'{16'h0ABC, 16'h0ABC, 16'h0000},
		'{16'hC123, 16'h0123, 16'h0000},
		'{16'h1FFF, 16'h0123, 16'h0001},
		'{16'h2000, 16'h0123, 16'h0002},
		'{16'h3555, 16'h0123, 16'h0003},
		'{16'h0FFF, 16'h0FFF, 16'h0000},
		'{16'h4000, 16'h0000, 16'h0000}
	};

	// Weak pull-down on the shared data-out line
	assign serial_out_line = serial_out_oe ? serial_out : 1'b0;

	dslc_core uut (.core_clk_i(core_clk_i), .rst_i(rst_i), .serial_clk_i(serial_clk),
		.frame_sel_n_i(frame_sel_n), .serial_in_i(serial_in),
		.async_clear_n_i(async_clear_n_i), .conv_ready_i(conv_ready_i),
		.serial_out_o(serial_out), .serial_out_oe_o(serial_out_oe),
		.frame_ready_o(frame_ready), .dac_code_o(dac_code), .power_mode_o(power_mode),
		.update_o(update));

	dslc_host_model host (.serial_clk_o(serial_clk), .frame_sel_n_o(frame_sel_n),
		.serial_in_o(serial_in), .serial_out_i(serial_out_line), .out_cap_o(out_cap));

	initial begin
		core_clk_i = 1'b0;
		forever #50 core_clk_i = ~core_clk_i;
	end

	always @(posedge core_clk_i) begin
		cyc++;
		if (update === 1'b1) upd_cnt++;
		if (cyc == 6000) begin
			mismatches++;
			give_verdict();
		end
	end

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic wait_upd(input int target);
		for (int i = 0; i < 400 && upd_cnt < target; i++) @(negedge core_clk_i);
		chk("updates", target[15:0], upd_cnt[15:0]);
	endtask : wait_upd

	task automatic send(input logic [15:0] w);
		host.open_frame();
		host.shift_word(w);
		host.close_frame();
	endtask : send

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : give_verdict

	initial begin
		rst_i = 1'b1;
		async_clear_n_i = 1'b1;
		conv_ready_i = 1'b1;
		repeat (12) @(posedge core_clk_i);
		rst_i <= 1'b0;
		@(negedge core_clk_i);
		chk("code", 16'h0000, {4'h0, dac_code});
		chk("mode", 16'h0000, {14'h0000, power_mode});
		chk("oe", 16'h0000, {15'h0000, serial_out_oe});
		chk("ready", 16'h0001, {15'h0000, frame_ready});
		$display("test reset done");
		foreach (rows[i]) begin
			host.open_frame();
			chk("oe", 16'h0001, {15'h0000, serial_out_oe});
			host.shift_word(rows[i].frame);
			host.close_frame();
			wait_upd(i + 1);
			chk("code", rows[i].code, {4'h0, dac_code});
			chk("mode", rows[i].mode, {14'h0000, power_mode});
			chk("oe", 16'h0000, {15'h0000, serial_out_oe});
		end
		$display("test rows done");
		host.idle_clocks(3);
		chk("oe idle", 16'h0000, {15'h0000, serial_out_oe});
		host.open_frame();
		host.shift_word(16'h0A5C);
		host.shift_word(16'h03C6);
		host.close_frame();
		wait_upd(8);
		chk("code", 16'h03C6, {4'h0, dac_code});
		chk("chain out", 16'h0A5C, out_cap[16:1]);
		chk("idle shift", 16'h4000, {1'b0, out_cap[31:17]});
		$display("test chain done");
		@(posedge core_clk_i);
		async_clear_n_i <= 1'b0;
		repeat (4) @(negedge core_clk_i);
		chk("clear code", 16'h0000, {4'h0, dac_code});
		@(posedge core_clk_i);
		async_clear_n_i <= 1'b1;
		repeat (10) @(negedge core_clk_i);
		chk("held code", 16'h0000, {4'h0, dac_code});
		chk("no update", 16'h0008, upd_cnt[15:0]);
		send(16'h0246);
		wait_upd(9);
		chk("code", 16'h0246, {4'h0, dac_code});
		$display("test clear done");
		@(posedge core_clk_i);
		conv_ready_i <= 1'b0;
		for (int k = 1; k <= 9; k++) send(k[15:0]);
		chk("full", 16'h0000, {15'h0000, frame_ready});
		chk("stalled", 16'h0009, upd_cnt[15:0]);
		@(posedge core_clk_i);
		conv_ready_i <= 1'b1;
		wait_upd(17);
		repeat (20) @(negedge core_clk_i);
		chk("drained", 16'h0011, upd_cnt[15:0]);
		chk("code", 16'h0008, {4'h0, dac_code});
		chk("ready", 16'h0001, {15'h0000, frame_ready});
		$display("test fifo done");
		@(posedge core_clk_i);
		rst_i <= 1'b1;
		@(posedge core_clk_i);
		rst_i <= 1'b0;
		@(negedge core_clk_i);
		chk("code", 16'h0000, {4'h0, dac_code});
		$display("test second reset done");
		give_verdict();
	end
endmodule : dslc_core_tb
